// ---- pmc_power_clock.sv ----
/*
  Power mode (idle, stop, suspend) and system clock source control with
  its three special function registers, internal oscillator divider,
  missing clock detector and clock multiplier.
  Assumes the core pulses i_instr_done when an instruction completes and
  reads registers over the SFR port; clocks are modelled as tick enables.
*/
module pmc_power_clock
  import pmc_pkg::*;
#(
  parameter int MCD_CYCLES  = MCD_TIMEOUT_CYCLES,
  parameter int INT_OSC_DIV = 4,
  parameter int LOCK_CYCLES = 256
) (
  input  wire logic       i_clk_sys,          // System clock, 100 MHz
  input  wire logic       i_rst,              // External reset, active high
  input  wire logic [7:0] i_sfr_addr,         // SFR address
  input  wire logic [7:0] i_sfr_wdata,        // SFR write data
  input  wire logic       i_sfr_wr,           // SFR write strobe
  input  wire logic       i_sfr_rd,           // SFR read strobe
  output logic      [7:0] o_sfr_rdata,        // SFR read data, one cycle later
  output logic            o_sfr_hit,          // Read address was ours
  input  wire logic       i_instr_done,       // Core finished an instruction
  input  wire logic       i_suspend_set,      // Suspend bit written 1
  input  wire logic [1:0] i_int_osc_divider,  // Internal oscillator divide 2^n
  input  wire logic       i_mcd_enable,       // missing_clock_detector enable
  input  wire logic       i_irq_pending,      // Interrupt pending, ends idle
  input  wire logic       i_ext_osc,          // External oscillator pin
  input  wire logic       i_port_match,       // Port match pin event
  input  wire logic       i_comp_low,         // Comparator output is low
  input  wire logic       i_comp_wake_en,     // Comparator wake enabled
  output logic            o_sys_tick,         // system_clock tick
  output logic            o_cpu_tick,         // CPU clock tick
  output logic            o_periph_tick,      // Peripheral clock tick
  output logic            o_int_osc_run,      // Internal oscillator running
  output logic            o_port_match_on,    // Port match logic active
  output logic            o_wake,             // Non-reset wake pulse
  output logic            o_core_reset,       // Internal reset to core
  output logic [1:0]      o_mode              // Current power mode
);

  // Synchronisers: bit 0 ext osc, bit 1 port match, bit 2 comparator low
  logic [2:0] sync1, sync2;
  logic       ext_prev;
  logic       ext_tick;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1    <= '0;
      sync2    <= '0;
      ext_prev <= 1'b0;
    end else begin
      sync1    <= {i_comp_low, i_port_match, i_ext_osc};
      sync2    <= sync1;
      ext_prev <= sync2[0];
    end
  end

  // External oscillator keeps running in every mode
  assign ext_tick = sync2[0] && !ext_prev;

  // Registers and power mode state
  logic [5:0]  sw_flags, next_sw_flags;
  logic [1:0]  clk_src, next_clk_src;
  logic        mul_en, next_mul_en;
  logic        mul_init, next_mul_init;
  logic [2:0]  mul_scale, next_mul_scale;
  logic [1:0]  mul_sel, next_mul_sel;
  pmc_mode_t   mode, next_mode;
  logic        pend_stop, next_pend_stop;
  logic        pend_idle, next_pend_idle;
  logic        pend_susp, next_pend_susp;
  logic        wake, next_wake;
  logic [7:0]  rdata, next_rdata;
  logic        hit, next_hit;
  logic        mcd_fire, next_mcd_fire;
  logic [15:0] mcd_cnt, next_mcd_cnt;
  logic [7:0]  osc_cnt, next_osc_cnt;
  logic        int_tick, next_int_tick;
  logic        mul_tick;
  logic        mul_ready;
  logic        mul_init_pulse;
  logic        sys_tick;
  logic        dev_rst;
  logic        wr_pc, wr_cs, wr_cm;

  // An MISSING_CLOCK_DETECTOR timeout acts as an internal reset of this block as well
  assign dev_rst = i_rst || mcd_fire;
  assign wr_pc   = i_sfr_wr && i_sfr_addr == ADDR_POWER_CONTROL;
  assign wr_cs   = i_sfr_wr && i_sfr_addr == ADDR_SYSTEM_CLOCK_SELECT;
  assign wr_cm   = i_sfr_wr && i_sfr_addr == ADDR_CLOCK_MULT_CONTROL;
  assign mul_init_pulse = wr_cm && i_sfr_wdata[CM_INIT_BIT] && i_sfr_wdata[CM_EN_BIT];

  pmc_multiplier #(
    .PERIOD_W    (16),
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_mul (
    .i_clk_sys  (i_clk_sys),
    .i_rst      (dev_rst),
    .i_src_tick (mul_sel[MSEL_EXT_BIT] ? ext_tick : int_tick),
    .i_enable   (mul_en),
    .i_init     (mul_init_pulse),
    .i_x4       (mul_sel[MSEL_X4_BIT]),
    .i_scale    (mul_scale),
    .o_tick     (mul_tick),
    .o_ready    (mul_ready)
  );

  always_comb begin
    unique case (clk_src)
      SRC_INTERNAL:   sys_tick = int_tick;
      SRC_EXTERNAL:   sys_tick = ext_tick;
      SRC_MULTIPLIER: sys_tick = mul_tick;
      default:        sys_tick = int_tick;
    endcase
  end

  always_comb begin
    next_sw_flags  = sw_flags;
    next_clk_src   = clk_src;
    next_mul_en    = mul_en;
    next_mul_init  = mul_init;
    next_mul_scale = mul_scale;
    next_mul_sel   = mul_sel;
    next_mode      = mode;
    next_pend_stop = pend_stop;
    next_pend_idle = pend_idle;
    next_pend_susp = pend_susp;
    next_wake      = 1'b0;
    next_hit       = 1'b0;
    next_rdata     = rdata;
    next_mcd_fire  = 1'b0;
    next_mcd_cnt   = mcd_cnt;
    next_osc_cnt   = osc_cnt;
    next_int_tick  = 1'b0;

    if (wr_pc) begin
      next_sw_flags = i_sfr_wdata[PC_FLAGS_MSB:PC_FLAGS_LSB];
      if (i_sfr_wdata[PC_STOP_BIT]) begin
        next_pend_stop = 1'b1;
      end
      if (i_sfr_wdata[PC_IDLE_BIT]) begin
        next_pend_idle = 1'b1;
      end
    end
    if (wr_cs) begin
      next_clk_src = i_sfr_wdata[1:0];
    end
    if (wr_cm) begin
      next_mul_en    = i_sfr_wdata[CM_EN_BIT];
      next_mul_init  = i_sfr_wdata[CM_INIT_BIT];
      next_mul_scale = i_sfr_wdata[CM_DIV_MSB:CM_DIV_LSB];
      next_mul_sel   = i_sfr_wdata[CM_SEL_MSB:CM_SEL_LSB];
    end
    if (i_suspend_set) begin
      next_pend_susp = 1'b1;
    end

    if (i_sfr_rd) begin
      next_hit = 1'b1;
      unique case (i_sfr_addr)
        ADDR_POWER_CONTROL:       next_rdata = {sw_flags, 2'b00};
        ADDR_SYSTEM_CLOCK_SELECT: next_rdata = {6'b000000, clk_src};
        ADDR_CLOCK_MULT_CONTROL:  next_rdata = {mul_en, mul_init, mul_ready,
                                                mul_scale, mul_sel};
        default: begin
          next_rdata = 8'h00;
          next_hit   = 1'b0;
        end
      endcase
    end

    // Mode changes take effect once the setting instruction completes
    unique case (mode)
      PMC_RUN: begin
        if (i_instr_done) begin
          // A bit set by the completing instruction itself must not be lost
          if (next_pend_stop) begin
            next_mode = PMC_STOP;
          end else if (next_pend_susp) begin
            next_mode = PMC_SUSPEND;
          end else if (next_pend_idle) begin
            next_mode = PMC_IDLE;
          end
          next_pend_stop = 1'b0;
          next_pend_susp = 1'b0;
          next_pend_idle = 1'b0;
        end
      end
      PMC_IDLE: begin
        if (i_irq_pending) begin
          next_mode = PMC_RUN;
        end
      end
      PMC_STOP: begin
        next_mode = PMC_STOP;
      end
      PMC_SUSPEND: begin
        if (sync2[1] || (sync2[2] && i_comp_wake_en)) begin
          next_mode = PMC_RUN;
          next_wake = 1'b1;
        end
      end
    endcase

    // Internal oscillator halts in stop and suspend
    if (mode != PMC_STOP && mode != PMC_SUSPEND) begin
      if (osc_cnt >= 8'((INT_OSC_DIV << i_int_osc_divider) - 1)) begin
        next_osc_cnt  = '0;
        next_int_tick = 1'b1;
      end else begin
        next_osc_cnt = osc_cnt + 8'h01;
      end
    end

    // Missing clock detector watches for a silent system clock
    if (!i_mcd_enable || sys_tick) begin
      next_mcd_cnt = '0;
    end else if (mcd_cnt >= 16'(MCD_CYCLES - 1)) begin
      next_mcd_cnt  = '0;
      next_mcd_fire = 1'b1;
    end else begin
      next_mcd_cnt = mcd_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (dev_rst) begin
      sw_flags  <= RESET_POWER_CONTROL[PC_FLAGS_MSB:PC_FLAGS_LSB];
      clk_src   <= RESET_SYSTEM_CLOCK_SEL[1:0];
      mul_en    <= RESET_CLOCK_MULT_CONTROL[CM_EN_BIT];
      mul_init  <= RESET_CLOCK_MULT_CONTROL[CM_INIT_BIT];
      mul_scale <= RESET_CLOCK_MULT_CONTROL[CM_DIV_MSB:CM_DIV_LSB];
      mul_sel   <= RESET_CLOCK_MULT_CONTROL[CM_SEL_MSB:CM_SEL_LSB];
      mode      <= PMC_RUN;
      pend_stop <= 1'b0;
      pend_idle <= 1'b0;
      pend_susp <= 1'b0;
      wake      <= 1'b0;
      rdata     <= 8'h00;
      hit       <= 1'b0;
      mcd_cnt   <= '0;
      osc_cnt   <= '0;
      int_tick  <= 1'b0;
    end else begin
      sw_flags  <= next_sw_flags;
      clk_src   <= next_clk_src;
      mul_en    <= next_mul_en;
      mul_init  <= next_mul_init;
      mul_scale <= next_mul_scale;
      mul_sel   <= next_mul_sel;
      mode      <= next_mode;
      pend_stop <= next_pend_stop;
      pend_idle <= next_pend_idle;
      pend_susp <= next_pend_susp;
      wake      <= next_wake;
      rdata     <= next_rdata;
      hit       <= next_hit;
      mcd_cnt   <= next_mcd_cnt;
      osc_cnt   <= next_osc_cnt;
      int_tick  <= next_int_tick;
    end
  end

  // Fire flop sits outside dev_rst so the pulse is not cut by itself
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mcd_fire <= 1'b0;
    end else begin
      mcd_fire <= next_mcd_fire;
    end
  end

  // Registers keep their contents in suspend; only ticks are gated
  assign o_sys_tick      = sys_tick;
  assign o_cpu_tick      = sys_tick && mode == PMC_RUN;
  assign o_periph_tick   = sys_tick && (mode == PMC_RUN || mode == PMC_IDLE);
  assign o_int_osc_run   = mode != PMC_STOP && mode != PMC_SUSPEND;
  assign o_port_match_on = 1'b1;
  assign o_wake          = wake;
  assign o_core_reset    = mcd_fire;
  assign o_mode          = mode;
  assign o_sfr_rdata     = rdata;
  assign o_sfr_hit       = hit;

endmodule : pmc_power_clock

// ---- pmc_pkg.sv ----
/*
  Shared constants for the power mode and system clock control block:
  register addresses, field positions, reset values, clock source codes
  and timing figures.
  Assumes a 100 MHz i_clk_sys and an 8-bit special function register port.
*/
package pmc_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_POWER_CONTROL       = 8'h87;
  localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT = 8'h8F;
  localparam logic [7:0] ADDR_CLOCK_MULT_CONTROL  = 8'h97;

  localparam logic [7:0] RESET_POWER_CONTROL      = 8'h00;
  localparam logic [7:0] RESET_SYSTEM_CLOCK_SEL   = 8'h00;
  localparam logic [7:0] RESET_CLOCK_MULT_CONTROL = 8'h00;

  // power_control fields
  localparam int PC_IDLE_BIT  = 0;
  localparam int PC_STOP_BIT  = 1;
  localparam int PC_FLAGS_LSB = 2;
  localparam int PC_FLAGS_MSB = 7;

  // clock_multiplier_control fields
  localparam int CM_SEL_LSB   = 0;
  localparam int CM_SEL_MSB   = 1;
  localparam int CM_DIV_LSB   = 2;
  localparam int CM_DIV_MSB   = 4;
  localparam int CM_READY_BIT = 5;
  localparam int CM_INIT_BIT  = 6;
  localparam int CM_EN_BIT    = 7;

  // clock_source_field codes
  localparam logic [1:0] SRC_INTERNAL   = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL   = 2'h1;
  localparam logic [1:0] SRC_MULTIPLIER = 2'h2;

  // multiplier_input_select bit meanings
  localparam int MSEL_EXT_BIT = 0;
  localparam int MSEL_X4_BIT  = 1;

  localparam logic [2:0] SCALE_UNITY = 3'h0;

  // Timing
  localparam int CLK_PERIOD_NS      = 10;
  localparam int MCD_TIMEOUT_US     = 100;
  localparam int MCD_TIMEOUT_CYCLES = (MCD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP,
    PMC_SUSPEND
  } pmc_mode_t;

endpackage : pmc_pkg

// ---- pmc_multiplier.sv ----
/*
  Clock multiplier model: measures the period of its input clock tick,
  produces ticks at two or four times that rate, scales only the times-four ticks by 2/N and
  reports lock after an initialisation period.
  Assumes i_src_tick is a one-cycle enable pulse on i_clk_sys.
*/
module pmc_multiplier
  import pmc_pkg::*;
#(
  parameter int PERIOD_W    = 16,
  parameter int LOCK_CYCLES = 256
) (
  input  wire logic       i_clk_sys,   // System clock
  input  wire logic       i_rst,       // Synchronous reset
  input  wire logic       i_src_tick,  // Selected input clock tick
  input  wire logic       i_enable,    // multiplier_enable
  input  wire logic       i_init,      // Initialise request pulse
  input  wire logic       i_x4,        // Times four when set
  input  wire logic [2:0] i_scale,     // multiplier_scaling
  output logic            o_tick,      // Scaled output tick
  output logic            o_ready      // multiplier_ready
);

  logic [PERIOD_W-1:0] period_cnt, next_period_cnt;
  logic [PERIOD_W-1:0] period, next_period;
  logic [PERIOD_W-1:0] phase, next_phase;
  logic [PERIOD_W-1:0] step;
  logic [PERIOD_W-1:0] lock_cnt, next_lock_cnt;
  logic                locking, next_locking;
  logic                ready, next_ready;
  logic [3:0]          acc, next_acc;
  logic                tick_q, next_tick;
  logic                raw;
  logic [3:0]          n_div;

  always_comb begin
    step            = i_x4 ? (period >> 2) : (period >> 1);
    n_div           = {1'b0, i_scale};
    next_period_cnt = period_cnt + 1'b1;
    next_period     = period;
    next_phase      = phase + 1'b1;
    next_lock_cnt   = lock_cnt;
    next_locking    = locking;
    next_ready      = ready;
    next_acc        = acc;
    next_tick       = 1'b0;
    raw             = 1'b0;
    if (i_src_tick) begin
      next_period     = period_cnt + 1'b1;
      next_period_cnt = '0;
      next_phase      = '0;
      raw             = (step != '0);
    end else if (step != '0 && phase >= step - 1'b1) begin
      next_phase = '0;
      raw        = 1'b1;
    end
    // Odd 2/N settings give uneven tick spacing, hence the non-50% duty
    if (raw && ready) begin
      // Codes up to 010 give unity; from 011 two ticks pass for every N
      if (!i_x4 || i_scale == SCALE_UNITY || n_div <= 4'h2) begin
        next_tick = 1'b1;
      end else if (acc + 4'h2 >= n_div) begin
        next_acc  = acc + 4'h2 - n_div;
        next_tick = 1'b1;
      end else begin
        next_acc = acc + 4'h2;
      end
    end
    if (locking) begin
      next_lock_cnt = lock_cnt + 1'b1;
      if (lock_cnt >= PERIOD_W'(LOCK_CYCLES - 1) && period != '0) begin
        next_locking = 1'b0;
        next_ready   = 1'b1;
      end
    end
    if (i_init && i_enable) begin
      next_locking  = 1'b1;
      next_ready    = 1'b0;
      next_lock_cnt = '0;
    end
    if (!i_enable) begin
      next_locking = 1'b0;
      next_ready   = 1'b0;
      next_acc     = '0;
      next_tick    = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      period_cnt <= '0;
      period     <= '0;
      phase      <= '0;
      lock_cnt   <= '0;
      locking    <= 1'b0;
      ready      <= 1'b0;
      acc        <= '0;
      tick_q     <= 1'b0;
    end else begin
      period_cnt <= next_period_cnt;
      period     <= next_period;
      phase      <= next_phase;
      lock_cnt   <= next_lock_cnt;
      locking    <= next_locking;
      ready      <= next_ready;
      acc        <= next_acc;
      tick_q     <= next_tick;
    end
  end

  assign o_tick  = tick_q;
  assign o_ready = ready;

endmodule : pmc_multiplier

// ---- pmc_power_clock_sva.sv ----
/*
  Assertions on the power mode and register port outputs.
  Bound into pmc_power_clock from tb_top; sees only its ports.
*/
module pmc_power_clock_sva
  import pmc_pkg::*;
(
  input wire logic       i_clk_sys,      // Clock
  input wire logic       i_rst,          // Reset
  input wire logic [7:0] i_sfr_addr,     // Address
  input wire logic       i_sfr_rd,       // Read strobe
  input wire logic [7:0] o_sfr_rdata,    // Read data
  input wire logic       o_sfr_hit,      // Read hit
  input wire logic       i_instr_done,   // Instruction done
  input wire logic       i_mcd_enable,   // Detector enable
  input wire logic       i_port_match,   // Port match
  input wire logic       i_comp_low,     // Comparator low
  input wire logic       i_comp_wake_en, // Comparator wake
  input wire logic       o_cpu_tick,     // CPU tick
  input wire logic       o_periph_tick,  // Peripheral tick
  input wire logic       o_int_osc_run,  // Oscillator on
  input wire logic       o_core_reset,   // Internal reset
  input wire logic [1:0] o_mode          // Mode
);
  timeunit 1ns;
  timeprecision 100ps;

  logic ours;

  assign ours = (i_sfr_addr == ADDR_POWER_CONTROL) || (i_sfr_addr == ADDR_SYSTEM_CLOCK_SELECT)
             || (i_sfr_addr == ADDR_CLOCK_MULT_CONTROL);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  reg_hit_a: assert property (i_sfr_rd |=> o_sfr_hit == $past(ours))
    else $error("read hit flag wrong");
  stop_reads_zero_a: assert property ((i_sfr_rd && i_sfr_addr == ADDR_POWER_CONTROL)
    |=> o_sfr_rdata[1:0] == 2'h0) else $error("mode bits read nonzero");
  sel_high_zero_a: assert property ((i_sfr_rd && i_sfr_addr == ADDR_SYSTEM_CLOCK_SELECT)
    |=> o_sfr_rdata[7:2] == 6'h00) else $error("clock select upper bits nonzero");
  cpu_run_only_a: assert property (o_cpu_tick |-> o_mode == PMC_RUN)
    else $error("cpu tick outside run");
  periph_halt_a: assert property (o_mode[1] |-> !o_periph_tick)
    else $error("peripheral tick in stop or suspend");
  osc_halt_a: assert property (o_mode[1] |-> !o_int_osc_run)
    else $error("oscillator running in stop or suspend");
  stop_entry_a: assert property ((o_mode == PMC_STOP && $past(o_mode) == PMC_RUN)
    |-> $past(i_instr_done)) else $error("stop entered without instruction end");
  stop_hold_a: assert property ((o_mode == PMC_STOP && !o_core_reset && !$past(o_core_reset))
    |=> o_mode == PMC_STOP) else $error("stop left without reset");
  mcd_cause_a: assert property (o_core_reset |-> $past(i_mcd_enable))
    else $error("internal reset without detector");
  port_wake_a: assert property (($rose(i_port_match) && o_mode == PMC_SUSPEND)
    |-> ##[1:3] o_mode == PMC_RUN) else $error("port match did not wake");
  suspend_hold_a: assert property (((!i_port_match && !(i_comp_low && i_comp_wake_en))[*4]
    ##0 o_mode == PMC_SUSPEND && !o_core_reset) |=> o_mode == PMC_SUSPEND)
    else $error("suspend left early");
endmodule : pmc_power_clock_sva

// ---- tb_top.sv ----
/*
  Self-checking bench for pmc_power_clock: register port, clock
  sources, multiplier, idle, stop, detector and suspend.
  Assumes short detector and lock counts set by parameter.
*/
module tb_top
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       i_clk_sys, i_rst, i_sfr_wr, i_sfr_rd, i_instr_done, i_suspend_set;
  logic       i_mcd_enable, i_irq_pending, i_ext_osc, i_port_match, i_comp_low;
  logic       i_comp_wake_en, o_sfr_hit, o_sys_tick, o_cpu_tick, o_periph_tick;
  logic       o_int_osc_run, o_port_match_on, o_wake, o_core_reset, ext_run;
  logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, rdv;
  logic [1:0] i_int_osc_divider, o_mode;
  int         err_count, comparisons, cycles, n_sys, n_cpu, n_per, n_wake, n_crst, k;

  pmc_power_clock #(.MCD_CYCLES(50), .LOCK_CYCLES(16)) pmc_power_clock_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_instr_done(i_instr_done),
    .i_suspend_set(i_suspend_set), .i_int_osc_divider(i_int_osc_divider),
    .i_mcd_enable(i_mcd_enable), .i_irq_pending(i_irq_pending), .i_ext_osc(i_ext_osc),
    .i_port_match(i_port_match), .i_comp_low(i_comp_low), .i_comp_wake_en(i_comp_wake_en),
    .o_sys_tick(o_sys_tick), .o_cpu_tick(o_cpu_tick), .o_periph_tick(o_periph_tick),
    .o_int_osc_run(o_int_osc_run), .o_port_match_on(o_port_match_on), .o_wake(o_wake),
    .o_core_reset(o_core_reset), .o_mode(o_mode));

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Ticks and pulses are tallied here so tests only compare totals
  always @(posedge i_clk_sys) begin
    cycles++;
    n_sys += o_sys_tick;
    n_cpu += o_cpu_tick;
    n_per += o_periph_tick;
    n_wake += o_wake;
    n_crst += o_core_reset;
    if (ext_run && cycles % 8 == 0) i_ext_osc <= ~i_ext_osc;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : step

  task automatic count(input int n);
    {n_sys, n_cpu, n_per, n_wake, n_crst} = '0;
    step(n);
  endtask : count

  task automatic span(input int v, input int lo, input int hi);
    check({7'h00, v >= lo && v <= hi}, 8'h01);
  endtask : span

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_sfr_wr    <= 1'b1;
    i_sfr_addr  <= a;
    i_sfr_wdata <= d;
    @(posedge i_clk_sys);
    i_sfr_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    i_sfr_rd   <= 1'b1;
    i_sfr_addr <= a;
    @(posedge i_clk_sys);
    i_sfr_rd <= 1'b0;
    #1 rdv = o_sfr_rdata;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(rdv, exp);
  endtask : rdc

  // 0 instruction end, 1 suspend bit, 2 interrupt
  task automatic pulse(input int w);
    @(posedge i_clk_sys);
    case (w)
      0: i_instr_done <= 1'b1;
      1: i_suspend_set <= 1'b1;
      default: i_irq_pending <= 1'b1;
    endcase
    @(posedge i_clk_sys);
    {i_instr_done, i_suspend_set, i_irq_pending} <= 3'h0;
  endtask : pulse

  task automatic wait_mode(input logic [1:0] m, input int lim);
    for (k = 0; k < lim && o_mode !== m; k++) @(posedge i_clk_sys);
    #1 check({6'h00, o_mode}, {6'h00, m});
  endtask : wait_mode

  task automatic reset_pulse;
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    step(1);
  endtask : reset_pulse

  task automatic go_suspend;
    count(0);
    pulse(1);
    pulse(0);
    wait_mode(PMC_SUSPEND, 3);
  endtask : go_suspend

  initial begin
    {i_rst, i_sfr_wr, i_sfr_rd, i_instr_done, i_suspend_set, i_mcd_enable} = 6'h21;
    {i_irq_pending, i_ext_osc, i_port_match, i_comp_low, i_comp_wake_en, ext_run} = 6'h00;
    {i_sfr_addr, i_sfr_wdata, i_int_osc_divider} = 18'h00000;
    {err_count, comparisons, cycles, n_sys, n_cpu, n_per, n_wake, n_crst} = '0;
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rdc(ADDR_POWER_CONTROL, RESET_POWER_CONTROL);
    check({7'h00, o_sfr_hit}, 8'h01);
    rdc(ADDR_SYSTEM_CLOCK_SELECT, RESET_SYSTEM_CLOCK_SEL);
    rdc(ADDR_CLOCK_MULT_CONTROL, RESET_CLOCK_MULT_CONTROL);
    rdc(8'h88, 8'h00);
    check({7'h00, o_sfr_hit}, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'hFC);
    rdc(ADDR_POWER_CONTROL, 8'hFC);
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'hFF);
    rdc(ADDR_SYSTEM_CLOCK_SELECT, 8'h03);
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'h00);
    count(80);
    span(n_sys, 19, 21);
    span(n_cpu, 19, 21);
    @(posedge i_clk_sys) i_int_osc_divider <= 2'h1;
    count(80);
    span(n_sys, 9, 11);
    ext_run = 1'b1;
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'h01);
    count(160);
    span(n_sys, 9, 11);
    // Internal source times four, unscaled
    wr(ADDR_CLOCK_MULT_CONTROL, 8'h82);
    wr(ADDR_CLOCK_MULT_CONTROL, 8'hC2);
    rdv = 8'h00;
    for (int p = 0; p < 60 && rdv[5] !== 1'b1; p++) rd(ADDR_CLOCK_MULT_CONTROL);
    check({7'h00, rdv[5]}, 8'h01);
    check({3'h0, rdv[4:0]}, 8'h02);
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'h02);
    count(80);
    span(n_sys, 38, 42);
    // Times four scaled by 2/4, then times two where scaling is ignored
    wr(ADDR_CLOCK_MULT_CONTROL, 8'h92);
    count(80);
    span(n_sys, 19, 21);
    wr(ADDR_CLOCK_MULT_CONTROL, 8'h90);
    count(80);
    span(n_sys, 19, 21);
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'h00);
    wr(ADDR_CLOCK_MULT_CONTROL, 8'h00);
    rdc(ADDR_CLOCK_MULT_CONTROL, 8'h00);
    wr(ADDR_POWER_CONTROL, 8'hFD);
    rdc(ADDR_POWER_CONTROL, 8'hFC);
    pulse(0);
    wait_mode(PMC_IDLE, 3);
    count(80);
    check(n_cpu[7:0], 8'h00);
    span(n_per, 9, 11);
    pulse(2);
    wait_mode(PMC_RUN, 4);
    wr(ADDR_SYSTEM_CLOCK_SELECT, 8'h01);
    wr(ADDR_POWER_CONTROL, 8'hFE);
    rdc(ADDR_POWER_CONTROL, 8'hFC);
    step(5);
    check({6'h00, o_mode}, {6'h00, PMC_RUN});
    pulse(0);
    wait_mode(PMC_STOP, 3);
    check({7'h00, o_int_osc_run}, 8'h00);
    count(160);
    span(n_sys, 9, 11);
    check(n_per[7:0], 8'h00);
    @(posedge i_clk_sys) i_port_match <= 1'b1;
    step(10);
    check({6'h00, o_mode}, {6'h00, PMC_STOP});
    @(posedge i_clk_sys) i_port_match <= 1'b0;
    reset_pulse();
    wait_mode(PMC_RUN, 1);
    rdc(ADDR_POWER_CONTROL, 8'h00);
    // The detector sees ticks while running, none once stopped
    @(posedge i_clk_sys) i_mcd_enable <= 1'b1;
    count(100);
    check(n_crst[7:0], 8'h00);
    wr(ADDR_POWER_CONTROL, 8'h02);
    pulse(0);
    wait_mode(PMC_STOP, 3);
    wait_mode(PMC_RUN, 80);
    check(n_crst[7:0], 8'h01);
    @(posedge i_clk_sys) i_mcd_enable <= 1'b0;
    wr(ADDR_POWER_CONTROL, 8'hA8);
    go_suspend();
    check({7'h00, o_int_osc_run}, 8'h00);
    count(20);
    check({6'h00, o_mode}, {6'h00, PMC_SUSPEND});
    check({n_per[6:0], o_port_match_on}, 8'h01);
    @(posedge i_clk_sys) i_port_match <= 1'b1;
    wait_mode(PMC_RUN, 4);
    check(n_wake[7:0], 8'h01);
    rdc(ADDR_POWER_CONTROL, 8'hA8);
    @(posedge i_clk_sys) i_port_match <= 1'b0;
    step(4);
    go_suspend();
    @(posedge i_clk_sys) i_comp_low <= 1'b1;
    step(10);
    check({6'h00, o_mode}, {6'h00, PMC_SUSPEND});
    @(posedge i_clk_sys) i_comp_wake_en <= 1'b1;
    wait_mode(PMC_RUN, 4);
    check(n_wake[7:0], 8'h01);
    @(posedge i_clk_sys) {i_comp_low, i_comp_wake_en} <= 2'h0;
    step(4);
    go_suspend();
    reset_pulse();
    wait_mode(PMC_RUN, 1);
    check(n_wake[7:0], 8'h00);
    rdc(ADDR_POWER_CONTROL, 8'h00);
    results();
  end
endmodule : tb_top

bind pmc_power_clock pmc_power_clock_sva pmc_power_clock_sva_i (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sfr_addr(i_sfr_addr), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .i_instr_done(i_instr_done),
  .i_mcd_enable(i_mcd_enable), .i_port_match(i_port_match), .i_comp_low(i_comp_low),
  .i_comp_wake_en(i_comp_wake_en), .o_cpu_tick(o_cpu_tick), .o_periph_tick(o_periph_tick),
  .o_int_osc_run(o_int_osc_run), .o_core_reset(o_core_reset), .o_mode(o_mode));
